// ==== hdl/ddr_access_pkg.sv ====
// Function
// - Command pins are sampled only on rising link clock edges; controller holds them valid there.
// - The rising edge is where the true clock rises and the complement falls.
// - Device drives the strobe with read data; controller drives it with write data.
// - Read strobe edges align with data edges; write strobe edges sit mid-window.
// - Write data captured on both strobe edges; read data launched on both edges.
// - Burst length of 2, 4 or 8 applies to reads and writes alike.
// - Read latency of 2, 2.5 or 3 cycles, with optional 1.5.
// - Activate uses the sampled bank and address to open one row.
// - Read or write uses the sampled bank and address as first column.
// - A burst walks the programmed number of columns in the programmed order.
// - Auto precharge closes the row by itself when its burst ends.
// - Four independent banks; work in one overlaps transfers in another.
// - The array moves one double word per cycle, two halves at the pins.
// - Mask sampled like write data; a masked location stays unwritten.
// - Auto refresh, self refresh and power-down modes are provided.
// - Output edges follow the clock only while the delay-locked loop is enabled; without it no read data or strobe is driven.
package ddr_access_pkg;

    // Address layout seen by the command decoder.
    localparam int ADDR_W = 13;
    localparam int AUTO_PRE_BIT = 10;

    // Commands on row strobe, column strobe and write enable, all active low.
    typedef enum logic [2:0] {
        CMD_MODE = 3'h0,
        CMD_REFRESH = 3'h1,
        CMD_PRECHARGE = 3'h2,
        CMD_ACTIVATE = 3'h3,
        CMD_WRITE = 3'h4,
        CMD_READ = 3'h5,
        CMD_STOP = 3'h6,
        CMD_NOP = 3'h7
    } cmd_t;

    // Power states of the device.
    typedef enum logic [1:0] {
        PWR_RUN = 2'h0,
        PWR_DOWN = 2'h1,
        PWR_SELF = 2'h2
    } pwr_t;

    // Burst length codes and the beat masks they give.
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] MASK_2 = 3'h1;
    localparam logic [2:0] MASK_4 = 3'h3;
    localparam logic [2:0] MASK_8 = 3'h7;

    // Read latency codes and the whole-cycle part of each.
    localparam logic [2:0] LAT_3 = 3'h3;
    localparam logic [2:0] LAT_1P5 = 3'h5;
    localparam logic [2:0] LAT_2P5 = 3'h6;
    localparam logic [1:0] WHOLE_1 = 2'h1;
    localparam logic [1:0] WHOLE_2 = 2'h2;
    localparam logic [1:0] WHOLE_3 = 2'h3;

    // Static configuration from the system side.
    typedef struct packed {
        logic dll_enable;
        logic interleave;
        logic [2:0] burst_length;
        logic [2:0] read_latency_setting;
    } cfg_t;

    // Device state reported to the system side.
    typedef struct packed {
        logic [3:0] bank_open;
        logic power_down;
        logic self_refresh;
    } stat_t;

endpackage : ddr_access_pkg

// ==== hdl/ddr_sdram_access_interface.sv ====
`timescale 1ns/100ps
`default_nettype none

module ddr_sdram_access_interface
    import ddr_access_pkg::*;
#(
    parameter int DQ_W = 8,
    parameter int ROW_W = 4,
    parameter int COL_W = 5
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire cfg_t mode_cfg,
    output var stat_t device_status,
    input wire logic differential_clock_true,
    input wire logic differential_clock_comp,
    input wire logic clock_enable,
    input wire logic chip_select_n,
    input wire logic row_strobe_n,
    input wire logic column_strobe_n,
    input wire logic write_enable_n,
    input wire logic bank_select_bit0,
    input wire logic bank_select_bit1,
    input wire logic [ADDR_W-1:0] address,
    input wire logic write_byte_mask,
    input wire logic [DQ_W-1:0] data_in,
    output logic [DQ_W-1:0] data_out,
    output logic data_oe,
    input wire logic strobe_in,
    output logic strobe_out,
    output logic strobe_oe
);

    localparam int MA_W = 2 + ROW_W + COL_W;
    localparam int MEM_D = 1 << MA_W;

    logic link_clk;
    logic lrst_meta_reg, lrst_n_reg;
    cfg_t cfg_meta_reg, cfg_reg;
    stat_t stat_link_reg, stat_meta_reg, stat_sync_reg;
    pwr_t pwr_reg;
    cmd_t cmd;
    logic cmd_live;
    logic [1:0] cmd_bank;
    logic [3:0] bank_onehot;
    logic [ROW_W-1:0] cmd_row;
    logic [COL_W-1:0] cmd_col;
    logic cmd_ap;
    logic act_fire, rd_fire, wr_fire, pre_fire, ref_fire, stop_fire;
    logic [3:0] bank_open_reg;
    logic [ROW_W-1:0] bank_row_reg [4];
    logic burst_act_reg, burst_wr_reg, burst_hold_reg, burst_ap_reg;
    logic [1:0] burst_bank_reg;
    logic [COL_W-1:0] burst_col_reg;
    logic [1:0] burst_cnt_reg;
    logic [2:0] beat_mask;
    logic burst_last, burst_step, wr_commit, ap_close;
    logic [1:0] lat_whole;
    logic lat_half;
    logic [DQ_W-1:0] mem [MEM_D];
    logic [MA_W-1:0] beat_addr [2];
    logic [1:0][DQ_W-1:0] array_word;
    logic [DQ_W-1:0] cap_rise_reg;
    logic mask_rise_reg;
    logic [1:0][DQ_W-1:0] cap_pair_reg;
    logic [1:0] cap_mask_reg;
    logic [2:0] pipe_vld_reg;
    logic [1:0][DQ_W-1:0] pipe_dat_reg [3];
    logic out_vld;
    logic [1:0][DQ_W-1:0] out_dat;
    logic [DQ_W-1:0] hold_b1_reg;
    logic hold_vld_reg, rd_drive;

    // Column of one beat inside a burst, sequential or interleaved.
    function automatic logic [COL_W-1:0] beat_col(input logic [COL_W-1:0] start, input logic [2:0] msk,
                                                  input logic ilv, input logic [2:0] idx);
        logic [COL_W-1:0] m;
        logic [COL_W-1:0] i;
        m = COL_W'(msk);
        i = COL_W'(idx);
        if (ilv) begin
            beat_col = start ^ i;
        end else begin
            beat_col = (start & ~m) | ((start + i) & m);
        end
    endfunction : beat_col

    // The rising edge is the crossing of true going high and complement going low.
    assign link_clk = differential_clock_true & ~differential_clock_comp;

    // Reset for the link side: asserts at once, releases on a link edge.
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            lrst_meta_reg <= 1'b0;
            lrst_n_reg <= 1'b0;
        end else begin
            lrst_meta_reg <= 1'b1;
            lrst_n_reg <= lrst_meta_reg;
        end
    end

    // Configuration levels cross into the link domain through two stages.
    always_ff @(posedge link_clk or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            cfg_meta_reg <= '0;
            cfg_reg <= '0;
        end else begin
            cfg_meta_reg <= mode_cfg;
            cfg_reg <= cfg_meta_reg;
        end
    end

    // Status is registered on the link side, then crosses to the system side.
    always_ff @(posedge link_clk or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            stat_link_reg <= '0;
        end else begin
            stat_link_reg <= '{bank_open: bank_open_reg, power_down: pwr_reg == PWR_DOWN,
                               self_refresh: pwr_reg == PWR_SELF};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_meta_reg <= '0;
            stat_sync_reg <= '0;
        end else begin
            stat_meta_reg <= stat_link_reg;
            stat_sync_reg <= stat_meta_reg;
        end
    end

    assign device_status = stat_sync_reg;

    // Command decode; a command counts only when selected, the clock is enabled and the device runs; refresh needs only the select.
    assign cmd = cmd_t'({row_strobe_n, column_strobe_n, write_enable_n});
    assign cmd_live = !chip_select_n && clock_enable && pwr_reg == PWR_RUN;
    assign cmd_bank = {bank_select_bit1, bank_select_bit0};
    assign bank_onehot = 4'h1 << cmd_bank;
    assign cmd_row = address[ROW_W-1:0];
    assign cmd_col = address[COL_W-1:0];
    assign cmd_ap = address[AUTO_PRE_BIT];
    assign act_fire = cmd_live && cmd == CMD_ACTIVATE;
    assign rd_fire = cmd_live && cmd == CMD_READ;
    assign wr_fire = cmd_live && cmd == CMD_WRITE;
    assign pre_fire = cmd_live && cmd == CMD_PRECHARGE;
    assign stop_fire = cmd_live && cmd == CMD_STOP;
    // Auto refresh needs no restore in a flip-flop array; it is accepted as a no-op.
    assign ref_fire = !chip_select_n && cmd == CMD_REFRESH;

    // Power state: clock enable low parks the device, with refresh it self-refreshes.
    always_ff @(posedge link_clk or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            pwr_reg <= PWR_RUN;
        end else begin
            case (pwr_reg)
                PWR_RUN: begin
                    if (!clock_enable) begin
                        pwr_reg <= ref_fire ? PWR_SELF : PWR_DOWN;
                    end
                end
                PWR_DOWN, PWR_SELF: begin
                    if (clock_enable) begin
                        pwr_reg <= PWR_RUN;
                    end
                end
                default: begin
                    pwr_reg <= PWR_RUN;
                end
            endcase
        end
    end

    // Burst length and read latency decode.
    always_comb begin
        case (cfg_reg.burst_length)
            BL_4: beat_mask = MASK_4;
            BL_8: beat_mask = MASK_8;
            default: beat_mask = MASK_2;
        endcase
        lat_half = 1'b0;
        case (cfg_reg.read_latency_setting)
            LAT_1P5: begin
                lat_whole = WHOLE_1;
                lat_half = 1'b1;
            end
            LAT_2P5: begin
                lat_whole = WHOLE_2;
                lat_half = 1'b1;
            end
            LAT_3: lat_whole = WHOLE_3;
            default: lat_whole = WHOLE_2;
        endcase
    end

    // Bank table: each bank opens and closes on its own; an activate wins over a close in one cycle.
    always_ff @(posedge link_clk or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            bank_open_reg <= 4'h0;
            for (int b = 0; b < 4; b++) begin
                bank_row_reg[b] <= '0;
            end
        end else begin
            if (pre_fire) begin
                bank_open_reg <= cmd_ap ? 4'h0 : bank_open_reg & ~bank_onehot;
            end
            if (ap_close) begin
                bank_open_reg[burst_bank_reg] <= 1'b0;
            end
            if (act_fire) begin
                bank_open_reg[cmd_bank] <= 1'b1;
                bank_row_reg[cmd_bank] <= cmd_row;
            end
        end
    end

    // Burst engine: one pair of beats per cycle; writes wait one cycle for the strobe.
    assign burst_last = burst_cnt_reg == beat_mask[2:1];
    assign burst_step = burst_act_reg && !burst_hold_reg;
    assign wr_commit = burst_step && burst_wr_reg;
    assign ap_close = burst_step && burst_last && burst_ap_reg;

    always_ff @(posedge link_clk or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            burst_act_reg <= 1'b0;
            burst_wr_reg <= 1'b0;
            burst_hold_reg <= 1'b0;
            burst_ap_reg <= 1'b0;
            burst_bank_reg <= 2'h0;
            burst_col_reg <= '0;
            burst_cnt_reg <= 2'h0;
        end else if (rd_fire || wr_fire) begin
            burst_act_reg <= 1'b1;
            burst_wr_reg <= wr_fire;
            burst_hold_reg <= wr_fire;
            burst_ap_reg <= cmd_ap;
            burst_bank_reg <= cmd_bank;
            burst_col_reg <= cmd_col;
            burst_cnt_reg <= 2'h0;
        end else if (stop_fire && !burst_wr_reg) begin
            burst_act_reg <= 1'b0;
        end else if (burst_act_reg) begin
            if (burst_hold_reg) begin
                burst_hold_reg <= 1'b0;
            end else if (burst_last) begin
                burst_act_reg <= 1'b0;
            end else begin
                burst_cnt_reg <= burst_cnt_reg + 2'h1;
            end
        end
    end

    // The two beats of the current pair form one double-width array word.
    for (genvar i = 0; i < 2; i++) begin : g_beat
        assign beat_addr[i] = {burst_bank_reg, bank_row_reg[burst_bank_reg],
                               beat_col(burst_col_reg, beat_mask, cfg_reg.interleave, {burst_cnt_reg, 1'(i)})};
        assign array_word[i] = mem[beat_addr[i]];
    end

    // Write capture on both strobe edges; the pair is complete after the falling edge.
    always_ff @(posedge strobe_in) begin
        cap_rise_reg <= data_in;
        mask_rise_reg <= write_byte_mask;
    end

    always_ff @(negedge strobe_in) begin
        cap_pair_reg <= {data_in, cap_rise_reg};
        cap_mask_reg <= {write_byte_mask, mask_rise_reg};
    end

    // Array write: the held pair is complete at the strobe's falling edge and stable for the second half of the link cycle that commits it.
    always_ff @(posedge link_clk) begin
        for (int i = 0; i < 2; i++) begin
            if (wr_commit && !cap_mask_reg[i]) begin
                mem[beat_addr[i]] <= cap_pair_reg[i];
            end
        end
    end

    // Read pipeline in whole cycles; the latency picks the tap.
    always_ff @(posedge link_clk or negedge lrst_n_reg) begin
        if (!lrst_n_reg) begin
            pipe_vld_reg <= 3'h0;
            for (int s = 0; s < 3; s++) begin
                pipe_dat_reg[s] <= '0;
            end
            hold_b1_reg <= '0;
            hold_vld_reg <= 1'b0;
        end else begin
            pipe_vld_reg <= {pipe_vld_reg[1:0], burst_step && !burst_wr_reg};
            pipe_dat_reg[0] <= array_word;
            pipe_dat_reg[1] <= pipe_dat_reg[0];
            pipe_dat_reg[2] <= pipe_dat_reg[1];
            hold_b1_reg <= out_dat[1];
            hold_vld_reg <= out_vld;
        end
    end

    assign out_vld = pipe_vld_reg[lat_whole - 2'h1];
    assign out_dat = pipe_dat_reg[lat_whole - 2'h1];

    // Double-rate launch: half-cycle latency shifts the pair by one clock phase.
    always_comb begin
        if (lat_half) begin
            data_out = link_clk ? hold_b1_reg : out_dat[0];
            rd_drive = link_clk ? hold_vld_reg : out_vld;
        end else begin
            data_out = link_clk ? out_dat[0] : out_dat[1];
            rd_drive = out_vld;
        end
    end

    // Strobe toggles with every beat, edge-aligned with the data; none without the loop.
    assign strobe_out = link_clk ^ lat_half;
    assign strobe_oe = rd_drive && cfg_reg.dll_enable;
    assign data_oe = rd_drive && cfg_reg.dll_enable;

    default clocking cb_link @(posedge link_clk);
    endclocking
    default disable iff (!lrst_n_reg);

    // A quiet cycle carries no command that could restart or cut a burst.
    logic quiet;
    assign quiet = !rd_fire && !wr_fire && !stop_fire && !act_fire;

    sequence rd4_s;
        rd_fire && beat_mask == MASK_4 ##1 (quiet && burst_act_reg) [*2];
    endsequence

    sequence rd_ap_s;
        rd_fire && cmd_ap && beat_mask == MASK_4 ##1 quiet [*2];
    endsequence

    chk_act_opens_bank: assert property (act_fire |=> bank_open_reg[$past(cmd_bank)])
        else $error("Activate did not open the bank.");
    chk_act_row_kept: assert property (act_fire |=> bank_row_reg[$past(cmd_bank)] == $past(cmd_row))
        else $error("Activate did not record the row.");
    chk_bank_isolation: assert property (act_fire && !ap_close |=>
        ((bank_open_reg ^ $past(bank_open_reg)) & ~$past(bank_onehot)) == 4'h0)
        else $error("Activate disturbed another bank.");
    chk_start_column: assert property (rd_fire || wr_fire |=>
        burst_col_reg == $past(cmd_col) && burst_bank_reg == $past(cmd_bank))
        else $error("Burst did not start at the sampled column.");
    chk_burst_four: assert property (rd4_s |=> !burst_act_reg)
        else $error("Burst of four ran the wrong number of cycles.");
    chk_latency_two: assert property (rd_fire && lat_whole == WHOLE_2 |-> ##3 out_vld)
        else $error("Read data late or early at latency two.");
    chk_latency_three: assert property (rd_fire && lat_whole == WHOLE_3 && cfg_reg.dll_enable |->
        ##4 (strobe_oe && data_oe))
        else $error("Strobe not driven with read data.");
    chk_auto_close: assert property (rd_ap_s |=> !bank_open_reg[$past(burst_bank_reg)])
        else $error("Auto precharge left the row open.");
    chk_mask_keeps: assert property (wr_commit && cap_mask_reg[0] |=>
        mem[$past(beat_addr[0])] == $past(array_word[0]))
        else $error("Masked beat was written.");
    chk_write_lands: assert property (wr_commit && !cap_mask_reg[1] |=>
        mem[$past(beat_addr[1])] == $past(cap_pair_reg[1]))
        else $error("Unmasked beat was not written.");
    chk_self_refresh: assert property (pwr_reg == PWR_RUN && !clock_enable && ref_fire |=> pwr_reg == PWR_SELF)
        else $error("Self refresh not entered.");

endmodule : ddr_sdram_access_interface

`default_nettype wire

// ==== tb/ddr_ctrl_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module ddr_ctrl_model
    import ddr_access_pkg::*;
(
    output logic lclk_t,
    output logic lclk_c,
    output logic clk_en,
    output logic chip_select_n,
    output logic [2:0] cmd_pins,
    output logic [1:0] bank,
    output logic [ADDR_W-1:0] address,
    output logic write_byte_mask,
    output logic [7:0] ctl_dq,
    output logic ctl_dqs,
    input wire logic [7:0] dq_bus,
    input wire logic dqs_bus,
    input wire logic data_oe
);
    // Free-running link clock pair, its phase offset from the system clock on purpose.
    initial begin
        lclk_t = 1'b0;
        #2.5;
        forever #6 lclk_t = ~lclk_t;
    end
    assign lclk_c = ~lclk_t;

    // Idle pins: deselected, enabled, strobe parked low.
    initial begin
        clk_en = 1'b1;
        chip_select_n = 1'b1;
        cmd_pins = CMD_NOP;
        bank = 2'h0;
        address = '0;
        write_byte_mask = 1'b0;
        ctl_dq = 8'h00;
        ctl_dqs = 1'b0;
    end

    // A command is set up mid-cycle, taken at the next rising edge, then deselected.
    task automatic cmd(input cmd_t c, input logic [1:0] b, input logic [ADDR_W-1:0] a, input logic en);
        @(negedge lclk_t);
        chip_select_n <= 1'b0;
        cmd_pins <= c;
        bank <= b;
        address <= a;
        clk_en <= en;
        @(posedge lclk_t);
        #1;
        chip_select_n <= 1'b1;
        cmd_pins <= CMD_NOP;
    endtask : cmd

    // Write burst: each beat settles a quarter cycle before its strobe edge.
    task automatic wr(input logic [1:0] b, input logic [ADDR_W-1:0] a, input int bl, input logic [63:0] d,
                      input logic [7:0] m);
        cmd(CMD_WRITE, b, a, 1'b1);
        @(negedge lclk_t);
        #3;
        for (int i = 0; i < bl; i++) begin
            ctl_dq <= d[8*i+:8];
            write_byte_mask <= m[i];
            if (i % 2 == 0)
                @(posedge lclk_t);
            else
                @(negedge lclk_t);
            ctl_dqs <= ~i[0];
            #3;
        end
        ctl_dq <= ~ctl_dq;
        write_byte_mask <= 1'b0;
        repeat (2) @(posedge lclk_t);
    endtask : wr

    // Read burst: sample each half cycle mid-phase, checking enable and strobe phase.
    task automatic rd(input logic [1:0] b, input logic [ADDR_W-1:0] a, input int h, input int bl, input logic drv,
                      output logic [63:0] d, output logic ok);
        d = '0;
        ok = 1'b1;
        cmd(CMD_READ, b, a, 1'b1);
        for (int j = 1; j <= h + bl; j++) begin
            @(lclk_t);
            #3;
            if (j >= h && j < h + bl) begin
                d[8*(j-h)+:8] = dq_bus;
                ok &= (data_oe === drv) && (!drv || dqs_bus === (lclk_t ^ h[0]));
            end else begin
                ok &= (data_oe === 1'b0);
            end
        end
    endtask : rd
endmodule : ddr_ctrl_model

`default_nettype wire

// ==== tb/ddr_sdram_access_interface_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none

module ddr_sdram_access_interface_tb_top
    import ddr_access_pkg::*;
;
    logic sys_clk;
    logic rst_n;
    cfg_t mode_cfg;
    stat_t device_status;
    wire logic lclk_t, lclk_c, clk_en, cs_n, wmask, ctl_dqs, data_oe, strobe_out, strobe_oe;
    wire logic [2:0] cmd_pins;
    wire logic [1:0] bank;
    wire logic [ADDR_W-1:0] address;
    wire logic [7:0] ctl_dq, data_out, dq_bus;
    wire logic dqs_bus;
    logic [7:0] ref_mem [0:2047];
    int n_errors;
    int n_checks;

    // The shared data and strobe wires follow whichever side enables its driver.
    assign dq_bus = data_oe ? data_out : ctl_dq;
    assign dqs_bus = strobe_oe ? strobe_out : ctl_dqs;

    // System clock.
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    ddr_sdram_access_interface i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .mode_cfg(mode_cfg), .device_status(device_status),
        .differential_clock_true(lclk_t), .differential_clock_comp(lclk_c), .clock_enable(clk_en),
        .chip_select_n(cs_n), .row_strobe_n(cmd_pins[2]), .column_strobe_n(cmd_pins[1]),
        .write_enable_n(cmd_pins[0]), .bank_select_bit0(bank[0]), .bank_select_bit1(bank[1]),
        .address(address), .write_byte_mask(wmask), .data_in(dq_bus), .data_out(data_out),
        .data_oe(data_oe), .strobe_in(dqs_bus), .strobe_out(strobe_out), .strobe_oe(strobe_oe)
    );

    ddr_ctrl_model i_ctrl (
        .lclk_t(lclk_t), .lclk_c(lclk_c), .clk_en(clk_en), .chip_select_n(cs_n), .cmd_pins(cmd_pins),
        .bank(bank), .address(address), .write_byte_mask(wmask), .ctl_dq(ctl_dq), .ctl_dqs(ctl_dqs),
        .dq_bus(dq_bus), .dqs_bus(dqs_bus), .data_oe(data_oe)
    );

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Column visited at beat i of a burst that starts at column c.
    function automatic int col_at(input int c, input int i, input int bl, input logic ilv);
        return (c & ~(bl - 1)) | (ilv ? ((c ^ i) & (bl - 1)) : ((c + i) & (bl - 1)));
    endfunction : col_at

    task automatic set_cfg(input logic dll, input logic ilv, input logic [2:0] blc, input logic [2:0] lat);
        @(negedge sys_clk);
        mode_cfg <= {dll, ilv, blc, lat};
        repeat (4) @(posedge lclk_t);
    endtask : set_cfg

    // Status crosses domains, so allow it a bounded settling time.
    task automatic wait_stat(input stat_t e);
        int k;
        for (k = 0; k < 40 && device_status !== e; k++) @(negedge sys_clk);
        check("device_status", device_status, e);
    endtask : wait_stat

    task automatic wr_ref(input int b, input int r, input int c, input int bl, input logic ilv,
                          input logic [63:0] d, input logic [7:0] m);
        i_ctrl.wr(2'(b), ADDR_W'(c), bl, d, m);
        for (int i = 0; i < bl; i++) begin
            if (!m[i])
                ref_mem[b*512 + r*32 + col_at(c, i, bl, ilv)] = d[8*i+:8];
        end
    endtask : wr_ref

    task automatic rd_chk(input int b, input int r, input int c, input int h, input int bl, input logic ilv,
                          input logic ap, input logic drv);
        logic [63:0] d;
        logic [63:0] e;
        logic ok;
        e = '0;
        i_ctrl.rd(2'(b), ADDR_W'(c) | (ADDR_W'(ap) << AUTO_PRE_BIT), h, bl, drv, d, ok);
        for (int i = 0; i < bl; i++) e[8*i+:8] = ref_mem[b*512 + r*32 + col_at(c, i, bl, ilv)];
        check("read_enable_strobe", 64'(ok), 64'h1);
        if (drv)
            check("read_data", d, e);
    endtask : rd_chk

    // Main sequence of scenarios.
    initial begin
        logic [2:0] lc [0:3];
        int hc [0:3];
        lc = '{3'h2, LAT_3, LAT_1P5, LAT_2P5};
        hc = '{4, 6, 3, 5};
        n_errors = 0;
        n_checks = 0;
        rst_n = 1'b0;
        mode_cfg = {1'b1, 1'b0, BL_4, 3'h2};
        repeat (10) @(negedge sys_clk);
        check("reset_status", device_status, '0);
        check("reset_oe", {data_oe, strobe_oe}, '0);
        rst_n <= 1'b1;
        repeat (8) @(posedge lclk_t);
        i_ctrl.cmd(CMD_ACTIVATE, 2'h0, 13'h1, 1'b1);
        wait_stat({4'h1, 2'b00});
        for (int b = 1; b <= 3; b++) begin
            for (int v = 0; v < 2; v++) begin
                set_cfg(1'b1, v[0], 3'(b), 3'h2);
                wr_ref(0, 1, 5 + b, 1 << b, v[0], 64'h8877665544332211 + 64'(b * 2 + v), 8'h00);
                for (int k = 0; k < 4; k++) begin
                    set_cfg(1'b1, v[0], 3'(b), lc[k]);
                    rd_chk(0, 1, 5 + b, hc[k], 1 << b, v[0], 1'b0, 1'b1);
                end
            end
        end
        set_cfg(1'b1, 1'b0, BL_4, 3'h2);
        wr_ref(0, 1, 10, 4, 1'b0, 64'h00000000a5b4c3d2, 8'h06);
        rd_chk(0, 1, 10, 4, 4, 1'b0, 1'b0, 1'b1);
        i_ctrl.cmd(CMD_ACTIVATE, 2'h2, 13'h3, 1'b1);
        wait_stat({4'h5, 2'b00});
        wr_ref(2, 3, 10, 4, 1'b0, 64'h000000005a6b7c8d, 8'h00);
        rd_chk(0, 1, 10, 4, 4, 1'b0, 1'b0, 1'b1);
        i_ctrl.cmd(CMD_PRECHARGE, 2'h0, 13'h0, 1'b1);
        wait_stat({4'h4, 2'b00});
        i_ctrl.cmd(CMD_ACTIVATE, 2'h0, 13'h2, 1'b1);
        wr_ref(0, 2, 10, 4, 1'b0, 64'h00000000f0e1d2c3, 8'h00);
        i_ctrl.cmd(CMD_PRECHARGE, 2'h0, 13'h0, 1'b1);
        i_ctrl.cmd(CMD_ACTIVATE, 2'h0, 13'h1, 1'b1);
        rd_chk(0, 1, 10, 4, 4, 1'b0, 1'b0, 1'b1);
        rd_chk(2, 3, 10, 4, 4, 1'b0, 1'b1, 1'b1);
        wait_stat({4'h1, 2'b00});
        i_ctrl.cmd(CMD_PRECHARGE, 2'h0, 13'h400, 1'b1);
        i_ctrl.cmd(CMD_REFRESH, 2'h0, 13'h0, 1'b1);
        wait_stat({4'h0, 2'b00});
        i_ctrl.cmd(CMD_NOP, 2'h0, 13'h0, 1'b0);
        wait_stat({4'h0, 2'b10});
        i_ctrl.cmd(CMD_ACTIVATE, 2'h1, 13'h0, 1'b0);
        repeat (8) @(posedge lclk_t);
        wait_stat({4'h0, 2'b10});
        i_ctrl.cmd(CMD_NOP, 2'h0, 13'h0, 1'b1);
        wait_stat({4'h0, 2'b00});
        i_ctrl.cmd(CMD_REFRESH, 2'h0, 13'h0, 1'b0);
        wait_stat({4'h0, 2'b01});
        i_ctrl.cmd(CMD_NOP, 2'h0, 13'h0, 1'b1);
        wait_stat({4'h0, 2'b00});
        set_cfg(1'b0, 1'b0, BL_4, 3'h2);
        i_ctrl.cmd(CMD_ACTIVATE, 2'h0, 13'h1, 1'b1);
        rd_chk(0, 1, 10, 4, 4, 1'b0, 1'b0, 1'b0);
        tally_and_finish();
    end

    // Cut a hang short.
    initial begin
        #400000;
        n_errors++;
        tally_and_finish();
    end
endmodule : ddr_sdram_access_interface_tb_top

`default_nettype wire
